// >>> hw/cell_cluster.sv
// cell_cluster: eight configurable logic cells with carry and cascade chains,
// local routing network and four shared control lines, configured over APB.
// assumes: configuration written before logic use, inputs synchronous to clock.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - arithmetic: first 3-LUT makes cell result
// - arithmetic: second 3-LUT makes carry out
// - arithmetic mode keeps cascade combining
// - up/down counter: enable, direction, load
// - counters: count LUT and carry LUT
// - counters: load selector before register
// - register loads on the next clock edge via clear/preset
// - clearable counter: selector ANDed with clear
// - clearable counter: clear takes cascade input
// - clear from fourth_data_input and both lines
// - clear/preset active low, unused held high
// - registered output inversion, fourth_data_input input inversion
// - cluster holds eight cells with chains
// - four control lines: two clocks, two clears
// - each control line has polarity inversion
// - control line source from global, pin, net
// - all cell outputs fed back locally
// - four globals as controls and data
// - normal mode: 4-LUT with fourth_data_input or carry
// - output combinational or registered
// - register acts as D, T, JK, SR in normal and arithmetic modes
module cell_cluster #(
  parameter int CELLS = 8,
  parameter int ROW_W = 8,
  parameter int PIN_W = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [cluster_pkg::GLOBAL_W-1:0] global_in,
  input wire logic [ROW_W-1:0] row_in,
  input wire logic [PIN_W-1:0] pin_in,
  input wire logic carry_in,
  input wire logic cascade_in,
  output logic [CELLS-1:0] cell_out,
  output logic carry_out,
  output logic cascade_out
);
  localparam int NET_W = cluster_pkg::NET_ROW_POS + ROW_W + PIN_W;

  // ===========================================
  // configuration registers
  logic [31:0] cfg_r [CELLS];
  logic [31:0] sel_r [CELLS];
  logic [31:0] ctrl_r;
  logic [CELLS-1:0] q_r;
  logic [3:0] line_prev_r;
  logic [NET_W-1:0] net;
  logic [3:0] line;
  logic [CELLS:0] carry_c;
  logic [CELLS:0] casc_c;
  logic [CELLS-1:0] comb_c;

  function automatic logic pick(input logic [NET_W-1:0] n, input logic [4:0] s);
    pick = (int'(s) < NET_W) ? n[s] : 1'b0;
  endfunction : pick

  // ===========================================
  // apb slave, one wait state per access
  logic access;
  logic [5:0] widx;
  logic mapped;
  logic [31:0] rdata;
  assign access = psel && penable;
  assign widx = paddr[7:2];
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= cluster_pkg::STATUS_OFS);

  always_comb begin
    rdata = 32'h0000_0000;
    if (paddr < cluster_pkg::CELL_SEL_BASE) begin
      rdata = cfg_r[widx[2:0]];
    end else if (paddr < cluster_pkg::CTRL_OFS) begin
      rdata = sel_r[widx[2:0]];
    end else if (paddr == cluster_pkg::CTRL_OFS) begin
      rdata = ctrl_r;
    end else if (paddr == cluster_pkg::STATUS_OFS) begin
      rdata = {22'h00_0000, carry_out, cascade_out, q_r};
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access && !pready;
      pslverr <= access && !pready && !mapped;
      prdata <= (access && !pready && mapped && !pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // configuration held static between writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= cluster_pkg::CTRL_RESET;
      for (int i = 0; i < CELLS; i++) begin
        cfg_r[i] <= cluster_pkg::CFG_RESET;
        sel_r[i] <= cluster_pkg::SEL_RESET;
      end
    end else if (access && pready && pwrite && mapped) begin
      if (paddr < cluster_pkg::CELL_SEL_BASE) begin
        cfg_r[widx[2:0]] <= pwdata;
      end else if (paddr < cluster_pkg::CTRL_OFS) begin
        sel_r[widx[2:0]] <= pwdata;
      end else if (paddr == cluster_pkg::CTRL_OFS) begin
        ctrl_r <= pwdata;
      end
    end
  end

  // ===========================================
  // local routing network and control lines
  assign net = {pin_in, row_in, cell_out, global_in};

  for (genvar k = 0; k < 4; k++) begin : g_line
    localparam int P = k * cluster_pkg::CTRL_FIELD_W;
    assign line[k] = pick(net, ctrl_r[P +: 5]) ^ ctrl_r[P + cluster_pkg::CTRL_INV_POS];
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      line_prev_r <= 4'h0;
    end else begin
      line_prev_r <= line;
    end
  end

  assign carry_c[0] = carry_in;
  assign casc_c[0] = cascade_in;

  // ===========================================
  // logic cells
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    logic [31:0] cfg;
    logic [15:0] lut;
    logic [3:0] d;
    logic d3;
    logic cin;
    logic ci;
    logic [2:0] aidx;
    logic [2:0] cidx;
    logic res;
    logic comb;
    logic nxt;
    logic cout;
    logic cout_casc;
    logic ffn;
    logic clr_n;
    logic pre_n;
    logic clk_edge;
    cluster_pkg::mode_t mode;
    cluster_pkg::ff_t fft;

    assign cfg = cfg_r[i];
    assign lut = cfg[cluster_pkg::LUT_POS +: 16];
    assign mode = cluster_pkg::mode_t'(cfg[cluster_pkg::MODE_POS +: 2]);
    assign fft = cluster_pkg::ff_t'(cfg[cluster_pkg::FF_POS +: 2]);
    for (genvar b = 0; b < 4; b++) begin : g_in
      assign d[b] = pick(net, sel_r[i][b * cluster_pkg::SRC_W +: 5]);
    end
    assign d3 = d[3] ^ cfg[cluster_pkg::INV_D3_POS];
    assign cin = carry_c[i];
    assign ci = casc_c[i];
    assign aidx = {cin, d[1], d[0]};
    assign cidx = {d[2], cin, q_r[i]};

    function automatic logic casc(input logic a, input logic c, input logic [31:0] f);
      if (!f[cluster_pkg::CASC_EN_POS]) begin
        casc = a;
      end else if (f[cluster_pkg::CASC_OR_POS]) begin
        casc = a | c;
      end else begin
        casc = a & c;
      end
    endfunction : casc

    always_comb begin
      res = 1'b0;
      cout = 1'b0;
      comb = 1'b0;
      nxt = 1'b0;
      cout_casc = 1'b0;
      unique case (mode)
        cluster_pkg::MODE_NORMAL: begin
          res = lut[{cfg[cluster_pkg::CIN_SEL_POS] ? cin : d3, d[2:0]}];
          comb = casc(res, ci, cfg);
          nxt = comb;
          cout_casc = comb;
        end
        cluster_pkg::MODE_ARITH: begin
          res = lut[{1'b0, aidx}];
          cout = lut[{1'b1, aidx}];
          comb = casc(res, ci, cfg);
          nxt = comb;
          cout_casc = comb;
        end
        cluster_pkg::MODE_UPDOWN: begin
          res = lut[{1'b0, cidx}];
          cout = lut[{1'b1, cidx}];
          comb = casc(res, ci, cfg);
          nxt = d3 ? d[0] : (d[1] ? res : q_r[i]);
          cout_casc = comb;
        end
        cluster_pkg::MODE_CLRCNT: begin
          res = lut[{1'b0, cidx}];
          cout = lut[{1'b1, cidx}];
          comb = res;
          nxt = (d3 ? d[0] : (d[1] ? res : q_r[i])) & ci;
          cout_casc = ci;
        end
      endcase
    end

    assign carry_c[i + 1] = cout;
    assign casc_c[i + 1] = cout_casc;

    // storage element behaviour, counters always use plain d
    always_comb begin
      ffn = nxt;
      if (mode == cluster_pkg::MODE_NORMAL || mode == cluster_pkg::MODE_ARITH) begin
        unique case (fft)
          cluster_pkg::FF_D: ffn = nxt;
          cluster_pkg::FF_T: ffn = q_r[i] ^ nxt;
          cluster_pkg::FF_JK: ffn = (nxt & ~q_r[i]) | (~d[2] & q_r[i]);
          cluster_pkg::FF_SR: ffn = nxt | (~d[2] & q_r[i]);
        endcase
      end
    end

    // active low clear and preset, unselected sources read high
    always_comb begin
      unique case (cfg[cluster_pkg::CLR_SEL_POS +: 2])
        2'h0: clr_n = 1'b1;
        2'h1: clr_n = d3;
        2'h2: clr_n = line[2];
        2'h3: clr_n = line[3];
      endcase
      unique case (cfg[cluster_pkg::PRE_SEL_POS +: 2])
        2'h1: pre_n = d3;
        2'h2: pre_n = line[2];
        default: pre_n = 1'b1;
      endcase
    end

    assign clk_edge = cfg[cluster_pkg::CLK_SEL_POS] ? (line[1] & ~line_prev_r[1]) : (line[0] & ~line_prev_r[0]);

    always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
        q_r[i] <= 1'b0;
      end else if (!clr_n) begin
        q_r[i] <= 1'b0;
      end else if (!pre_n) begin
        q_r[i] <= 1'b1;
      end else if (clk_edge) begin
        q_r[i] <= ffn;
      end
    end

    assign comb_c[i] = cfg[cluster_pkg::OUT_REG_POS] ? (q_r[i] ^ cfg[cluster_pkg::INV_OUT_POS]) : comb;
  end

  // ===========================================
  // registered outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cell_out <= '0;
      carry_out <= 1'b0;
      cascade_out <= 1'b0;
    end else begin
      cell_out <= comb_c;
      carry_out <= carry_c[CELLS];
      cascade_out <= casc_c[CELLS];
    end
  end
endmodule : cell_cluster

`default_nettype wire

// >>> pkg/cluster_pkg.sv
// cluster_pkg: register map, field layout and mode codes of the logic cell cluster.
// assumes: 32-bit APB register access, word aligned offsets.
package cluster_pkg;
  // ===========================================
  // register map
  localparam logic [7:0] CELL_CFG_BASE = 8'h00;
  localparam logic [7:0] CELL_SEL_BASE = 8'h20;
  localparam logic [7:0] CTRL_OFS = 8'h40;
  localparam logic [7:0] STATUS_OFS = 8'h44;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // ===========================================
  // cell configuration word fields
  localparam int LUT_POS = 0;
  localparam int MODE_POS = 16;
  localparam int CIN_SEL_POS = 18;
  localparam int OUT_REG_POS = 19;
  localparam int FF_POS = 20;
  localparam int CLK_SEL_POS = 22;
  localparam int CASC_EN_POS = 23;
  localparam int CASC_OR_POS = 24;
  localparam int CLR_SEL_POS = 25;
  localparam int PRE_SEL_POS = 27;
  localparam int INV_D3_POS = 29;
  localparam int INV_OUT_POS = 30;
  // ===========================================
  // select word fields
  localparam int SRC_W = 5;
  localparam int CTRL_FIELD_W = 6;
  localparam int CTRL_INV_POS = 5;
  // ===========================================
  // local network source layout
  localparam int GLOBAL_W = 4;
  localparam int NET_GLOBAL_POS = 0;
  localparam int NET_FB_POS = 4;
  localparam int NET_ROW_POS = 12;
  // ===========================================
  // modes and storage element kinds
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_ARITH = 2'h1,
    MODE_UPDOWN = 2'h3,
    MODE_CLRCNT = 2'h2
  } mode_t;
  typedef enum logic [1:0] {
    FF_D = 2'h0,
    FF_T = 2'h1,
    FF_JK = 2'h3,
    FF_SR = 2'h2
  } ff_t;
endpackage : cluster_pkg

// >>> sim/cell_cluster_props.sv
// cell_cluster_props: bus answer and reset checks at the cluster ports.
// assumes: bound into cell_cluster, single clock domain.
`timescale 1ns/1ns
`default_nettype none
module cell_cluster_props #(
  parameter int CELLS = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [CELLS-1:0] cell_out
);
  // ====
  // properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  property p_ans; psel && penable && !pready |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("access not answered");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_qual; pready |-> psel && penable; endproperty
  a_qual: assert property (p_qual) else $error("ready outside access");
  property p_rd0; (!pready || pwrite) |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("read data outside read");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_bad; pready && (paddr > 8'h44 || paddr[1:0] != 2'h0) |-> pslverr; endproperty
  a_bad: assert property (p_bad) else $error("bad address accepted");
  property p_good; pready && paddr <= 8'h44 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
  a_good: assert property (p_good) else $error("good address refused");
  property p_rst; $rose(resetn) |-> cell_out == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared");
  c_wr: cover property (pready && pwrite && !pslverr);
  c_rd: cover property (pready && !pwrite && prdata != 32'h0);
  c_err: cover property (pready && pslverr);
endmodule : cell_cluster_props
bind cell_cluster cell_cluster_props #(.CELLS(CELLS)) props_u (.clock(clock), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cell_out(cell_out));
`default_nettype wire

// >>> sim/neighbour_cells.sv
// neighbour_cells: lower neighbour on the carry and cascade chains.
// assumes: same clock and reset as the cluster.
`timescale 1ns/1ns
`default_nettype none
module neighbour_cells (
  input wire logic clock,
  input wire logic resetn,
  input wire logic carry_set,
  input wire logic cascade_set,
  output logic carry_in,
  output logic cascade_in
);
  // ====
  // chain drivers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      carry_in <= 1'b0;
      cascade_in <= 1'b1;
    end else begin
      carry_in <= carry_set;
      cascade_in <= cascade_set;
    end
  end
endmodule : neighbour_cells
`default_nettype wire

// >>> sim/lut_logic_cell_cluster_test.sv
// lut_logic_cell_cluster_test: self-checking bench for cell_cluster.
// assumes: neighbour_cells model and bound checker.
`timescale 1ns/1ns
`default_nettype none
module lut_logic_cell_cluster_test;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] global_in = 4'h8;
  logic [7:0] row_in = 8'h00;
  logic carry_set = 1'b0;
  logic cascade_set = 1'b1;
  logic [31:0] prdata, rd, wv;
  logic pready, pslverr, rerr, c, carry_in, cascade_in, carry_out, cascade_out;
  logic [7:0] cell_out, v;
  logic [8:0] s;
  int n_mismatch = 0;
  int num_checks = 0;
  int i, n;
  always #10 clock = ~clock;
  cell_cluster dut_u (.clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_in(global_in), .row_in(row_in), .pin_in(4'h0), .carry_in(carry_in),
    .cascade_in(cascade_in), .cell_out(cell_out), .carry_out(carry_out), .cascade_out(cascade_out));
  neighbour_cells nb_u (.clock(clock), .resetn(resetn), .carry_set(carry_set), .cascade_set(cascade_set),
    .carry_in(carry_in),
    .cascade_in(cascade_in));
  // ====
  // helpers
  function automatic logic [8:0] add_rev(input logic [7:0] a, input logic ci);
    logic [7:0] b;
    for (int k = 0; k < 8; k++) b[k] = a[7 - k];
    return {1'b0, a} + {1'b0, b} + {8'h00, ci};
  endfunction : add_rev
  task automatic results;
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_mismatch++;
      results();
    end
    @(posedge clock);
  endtask : apb
  task automatic tick(input int m);
    @(posedge clock);
    repeat (m) begin
      global_in[0] <= 1'b1;
      @(posedge clock);
      global_in[0] <= 1'b0;
      @(posedge clock);
    end
    repeat (2) @(posedge clock);
  endtask : tick
  // ====
  // main sequence
  initial begin
    void'($urandom(32'h2AF49DD5));
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    apb(1'b0, cluster_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", cluster_pkg::CTRL_RESET, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("cfg7", cluster_pkg::CFG_RESET, rd);
    apb(1'b1, 8'h02, 32'hFFFF_FFFF);
    chk("misaligned", 32'h1, 32'(rerr));
    apb(1'b0, 8'h48, 32'h0);
    chk("unmapped", 32'h1, 32'(rerr));
    apb(1'b1, cluster_pkg::STATUS_OFS, 32'hFF);
    chk("status_wr", 32'h0, 32'(rerr));
    wv = $urandom & 32'h000F_FFFF;
    apb(1'b1, 8'h24, wv);
    apb(1'b0, 8'h24, 32'h0);
    chk("sel1", wv, rd);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, 8'(4 * i), 32'h0001_E896);
      apb(1'b1, 8'(32 + 4 * i), 32'(12 + i) | (32'(19 - i) << 5));
    end
    for (n = 0; n < 6; n++) begin
      v = (n == 0) ? 8'hFF : 8'($urandom);
      c = 1'($urandom);
      row_in <= v;
      carry_set <= c;
      repeat (4) @(posedge clock);
      s = add_rev(v, c);
      chk("sum", 32'(s[7:0]), 32'(cell_out));
      chk("carry", 32'(s[8]), 32'(carry_out));
    end
    for (i = 0; i < 8; i++) begin
      apb(1'b1, 8'(4 * i), 32'h040B_8866);
      apb(1'b1, 8'(32 + 4 * i), 32'(12 + i) | 32'h0001_0020);
    end
    apb(1'b1, cluster_pkg::CTRL_OFS, 32'h0000_3000);
    v = {1'b0, 7'($urandom)} | 8'h01;
    carry_set <= 1'b1;
    row_in <= v;
    global_in <= 4'hC;
    tick(1);
    chk("load", 32'(v), 32'(cell_out));
    n = 1 + $urandom % 5;
    global_in <= 4'hA;
    tick(n);
    chk("count", 32'(v + 8'(n)), 32'(cell_out));
    global_in <= 4'h8;
    tick(2);
    chk("hold", 32'(v + 8'(n)), 32'(cell_out));
    apb(1'b0, cluster_pkg::STATUS_OFS, 32'h0);
    chk("status", 32'(v + 8'(n)), 32'(rd[7:0]));
    global_in <= 4'h0;
    repeat (3) @(posedge clock);
    chk("clear", 32'h0, 32'(cell_out));
    global_in <= 4'hC;
    tick(1);
    apb(1'b1, cluster_pkg::CTRL_OFS, 32'h0002_3000);
    repeat (2) @(posedge clock);
    chk("inverted", 32'h0, 32'(cell_out));
    apb(1'b1, cluster_pkg::CTRL_OFS, 32'h0000_3000);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, 8'(4 * i), 32'h000A_8866);
    end
    global_in <= 4'hC;
    tick(1);
    chk("clr_load", 32'(v), 32'(cell_out));
    cascade_set <= 1'b0;
    global_in <= 4'hA;
    tick(1);
    chk("sync_clear", 32'h0, 32'(cell_out));
    results();
  end
endmodule : lut_logic_cell_cluster_test
`default_nettype wire
